// ===== dv/far_side_model.sv
// Crystal and supply comparator seen from outside the block
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input  wire logic run,          // Crystal oscillating
  input  wire logic low,          // Supply under threshold
  output logic      xtal_clk,     // Crystal clock, 64 ns period
  output logic      supply_below  // Comparator level
);
  assign supply_below = low;
  // Crystal runs free; a halt freezes it so the detector sees silence
  initial begin
    xtal_clk = 1'b0;
    #7;
    forever #32 xtal_clk = run ? ~xtal_clk : xtal_clk;
  end
endmodule : far_side_model
`default_nettype wire

// ===== dv/test_rtc_trim_and_health_flags.sv
// Self-checking bench for the clock rate trim and health flags
`timescale 1ns/1ps
`default_nettype none
module test_rtc_trim_and_health_flags;
  import rtc_trim_pkg::*;
  logic core_clk, rst_n, wr, rd, run, low, xtal, below, thr, mon, tick;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [7:0] codes [4] = '{8'h09, 8'h46, 8'h01, 8'h99};  // In-range trims
  int bad_count, n_checks, cyc;
  // Short second and windows keep the run small
  rtc_trim_and_health_flags #(.COUNTS_PER_SEC(256), .SAMPLE_LEN(20), .HALT_LEN(16)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .xtal_clk(xtal), .host_wr_en(wr), .host_rd_en(rd),
    .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata), .supply_below(below),
    .supply_threshold_select(thr), .supply_monitor_en(mon), .second_tick(tick));
  far_side_model u_far (.run(run), .low(low), .xtal_clk(xtal), .supply_below(below));
  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  // Single-cycle strobes, driven just after the edge
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk); #2 wr = 1; addr = a; wdata = d;
    @(posedge core_clk); #2 wr = 0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk); #2 rd = 1; addr = a;
    @(posedge core_clk); #2 rd = 0;
    check(rdata, exp);
  endtask : rd_chk
  // Bounded wait for the next second pulse
  task automatic next_tick(output realtime t);
    int n = 0;
    do begin @(posedge core_clk); #1 n++; end while (tick !== 1'b1 && n < 20000);
    if (n >= 20000) begin check(8'h00, 8'h01); give_verdict(); end
    t = $realtime;
  endtask : next_tick
  task automatic reset_and_lock();
    rd_chk(ADDR_TRIM, 8'h00); rd_chk(ADDR_CTRL1, 8'h00); rd_chk(ADDR_CTRL2, 8'h10);
    rd_chk(4'h3, 8'h00);
    wr_reg(ADDR_TRIM, 8'h09); rd_chk(ADDR_TRIM, 8'h00);
    wr_reg(ADDR_CTRL1, 8'hC3); rd_chk(ADDR_CTRL1, 8'h00);
    wr_reg(ADDR_CTRL2, 8'hDF); rd_chk(ADDR_CTRL2, 8'h10);
    wr_reg(ADDR_CTRL2, 8'h20); rd_chk(ADDR_CTRL2, 8'h20);
    wr_reg(ADDR_CTRL2, 8'h50); rd_chk(ADDR_CTRL2, 8'h00);
    wr_reg(ADDR_CTRL2, 8'hA0); rd_chk(ADDR_CTRL2, 8'hA0); check({7'h0, thr}, 8'h01);
    wr_reg(ADDR_CTRL2, 8'h20); check({7'h0, thr}, 8'h00);
    wr_reg(ADDR_CTRL1, 8'h33); rd_chk(ADDR_CTRL1, 8'h33);
  endtask : reset_and_lock
  // Exactly one second of each period carries the whole correction
  task automatic trim_run(input logic [7:0] code);
    int per, d, v, odd, len;
    realtime t0, t1;
    per = code[7] ? 60 : 20;
    v = code[6:0];
    d = code[6] ? (v > 65 ? 2 * v - 256 : 0) : (v > 1 ? 2 * v - 2 : 0);
    wr_reg(ADDR_TRIM, code); rd_chk(ADDR_TRIM, code);
    next_tick(t0); next_tick(t0); next_tick(t0);
    odd = 0;
    repeat (per) begin
      next_tick(t1);
      len = int'((t1 - t0) / 64.0);
      t0 = t1;
      if (len < 254 || len > 258) begin
        odd++;
        check(8'((len - d - 254) inside {[0:4]}), 8'h01);
      end
    end
    check(8'(odd), 8'(d != 0));
  endtask : trim_run
  // Drop seen in a window, then sampling stops until cleared
  task automatic supply_drop();
    realtime t;
    @(posedge core_clk); #2 low = 1;
    next_tick(t); repeat (8) @(posedge core_clk);
    rd_chk(ADDR_CTRL2, 8'h60);
    next_tick(t); check({7'h0, mon}, 8'h00);
    wr_reg(ADDR_CTRL2, 8'h60); rd_chk(ADDR_CTRL2, 8'h60);
    low = 0; wr_reg(ADDR_CTRL2, 8'h20); rd_chk(ADDR_CTRL2, 8'h20);
    next_tick(t); check({7'h0, mon}, 8'h01);
  endtask : supply_drop
  task automatic osc_halt();
    @(posedge core_clk); #2 run = 0;
    repeat (60) @(posedge core_clk);
    #2 run = 1;
    repeat (4) @(posedge core_clk);
    rd_chk(ADDR_CTRL2, 8'h00);
    wr_reg(ADDR_CTRL2, 8'h20); rd_chk(ADDR_CTRL2, 8'h20);
  endtask : osc_halt
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  // Hang guard, well above the expected run
  initial begin
    cyc = 0;
    forever begin @(posedge core_clk); cyc++; if (cyc == 90000) begin bad_count++; give_verdict(); end end
  end
  initial begin
    rst_n = 0; wr = 0; rd = 0; addr = 0; wdata = 0; run = 1; low = 0; bad_count = 0; n_checks = 0;
    repeat (16) @(posedge core_clk);
    #2 rst_n = 1;
    repeat (4) @(posedge core_clk);
    reset_and_lock();
    foreach (codes[i]) trim_run(codes[i]);
    supply_drop();
    osc_halt();
    give_verdict();
  end
endmodule : test_rtc_trim_and_health_flags
`default_nettype wire

// ===== hdl/bit_sync.sv
// Two-stage synchroniser for a bundle of independent level signals
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter int W = 1                          // Number of bits carried
) (
  input  wire logic         clk,               // Destination clock
  input  wire logic         rst_n,             // Destination reset, active low
  input  wire logic [W-1:0] d,                 // Asynchronous input
  output logic      [W-1:0] q                  // Synchronised output
);

  logic [W-1:0] meta_ff;                       // First stage, read only by the second

  // ----------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : bit_sync

`default_nettype wire

// ===== hdl/rtc_trim_and_health_flags.sv
// Clock rate trim, timekeeping second generation and health monitor flags
`timescale 1ns/1ps
`default_nettype none

module rtc_trim_and_health_flags
  import rtc_trim_pkg::*;
#(
  parameter int COUNTS_PER_SEC = rtc_trim_pkg::XTAL_COUNTS_SEC, // Crystal cycles per second
  parameter int SAMPLE_LEN     = rtc_trim_pkg::SAMPLE_CYCLES,   // Core cycles of one supply sample
  parameter int HALT_LEN       = rtc_trim_pkg::HALT_CYCLES      // Core cycles of silence = halt
) (
  input  wire logic       core_clk,                // Core clock, 20 MHz
  input  wire logic       rst_n,                   // Power-on detector, active low
  input  wire logic       xtal_clk,                // Crystal clock domain
  input  wire logic       host_wr_en,              // Register write strobe
  input  wire logic       host_rd_en,              // Register read strobe
  input  wire logic [3:0] host_addr,               // Register address
  input  wire logic [7:0] host_wdata,              // Write data
  output logic      [7:0] host_rdata,              // Read data, registered
  input  wire logic       supply_below,            // Supply comparator, high = below threshold
  output logic            supply_threshold_select, // Comparator threshold choice
  output logic            supply_monitor_en,       // Comparator sampling window
  output logic            second_tick              // One-cycle pulse per timekept second
);

  import rtc_trim_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (COUNTS_PER_SEC < 256 || COUNTS_PER_SEC > 65536) begin : g_bad_counts
    $error("COUNTS_PER_SEC must lie between 256 and 65536");
  end
  if (SAMPLE_LEN < 1 || HALT_LEN < 4) begin : g_bad_lengths
    $error("SAMPLE_LEN must be at least 1 and HALT_LEN at least 4");
  end

  // ----------------------------------------------------------------
  // Reset synchronisers, one for each domain
  // ----------------------------------------------------------------
  logic [1:0] rst_core_ff;                     // Core reset release chain
  logic [1:0] rst_xtal_ff;                     // Crystal reset release chain
  logic       core_rst_n;                      // Core domain reset
  logic       xtal_rst_n;                      // Crystal domain reset

  // Release the core reset after two edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_core_ff <= 2'b00;
    end else begin
      rst_core_ff <= {rst_core_ff[0], 1'b1};
    end
  end

  // Release the crystal reset after two crystal edges
  always_ff @(posedge xtal_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_xtal_ff <= 2'b00;
    end else begin
      rst_xtal_ff <= {rst_xtal_ff[0], 1'b1};
    end
  end

  assign core_rst_n = rst_core_ff[1];
  assign xtal_rst_n = rst_xtal_ff[1];

  // ----------------------------------------------------------------
  // Register file (core domain)
  // ----------------------------------------------------------------
  logic [7:0] trim_ff;                         // Step select and trim value
  logic [7:0] ctrl1_ff;                        // Alarm enables, format, spares, periodic selects
  logic       thresh_sel_ff;                   // Supply threshold select
  logic       low_supply_ff;                   // Low-supply flag
  logic       osc_run_ff;                      // Oscillation-running flag, low = halt
  logic       powerup_ff;                      // Power-up flag
  logic [3:0] ctrl2_low_ff;                    // Spare one and the three interrupt flags
  logic       wr_trim;                         // Write hits trim
  logic       wr_ctrl1;                        // Write hits first control register
  logic       wr_ctrl2;                        // Write hits status register
  logic       halt_seen;                       // Crystal silence detected this cycle
  logic       low_seen;                        // Supply sample found a drop this cycle

  assign wr_trim  = host_wr_en && (host_addr == ADDR_TRIM);
  assign wr_ctrl1 = host_wr_en && (host_addr == ADDR_CTRL1);
  assign wr_ctrl2 = host_wr_en && (host_addr == ADDR_CTRL2);

  // Trim register; the layout is taken whole from the write data
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      trim_ff <= TRIM_RESET;
    end else if (powerup_ff) begin
      trim_ff <= TRIM_RESET;
    end else if (wr_trim) begin
      trim_ff <= host_wdata;
    end
  end

  // First control register, held clear while the power-up flag stands
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ctrl1_ff <= CTRL1_RESET;
    end else if (powerup_ff) begin
      ctrl1_ff <= CTRL1_RESET;
    end else if (wr_ctrl1) begin
      ctrl1_ff <= host_wdata;
    end
  end

  // Plain stored bits of the status register
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      thresh_sel_ff <= CTRL2_RESET[THRESH_SEL_BIT];
      ctrl2_low_ff  <= CTRL2_RESET[3:0];
    end else if (powerup_ff) begin
      thresh_sel_ff <= 1'b0;
      ctrl2_low_ff  <= 4'h0;
    end else if (wr_ctrl2) begin
      thresh_sel_ff <= host_wdata[THRESH_SEL_BIT];
      ctrl2_low_ff  <= host_wdata[3:0];
    end
  end

  // Power-up flag: set by reset, cleared only by writing zero
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      powerup_ff <= CTRL2_RESET[POWERUP_BIT];
    end else if (wr_ctrl2 && !host_wdata[POWERUP_BIT]) begin
      powerup_ff <= 1'b0;
    end
  end

  // Low-supply flag: a sample hit wins over a clearing write
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      low_supply_ff <= CTRL2_RESET[LOW_SUPPLY_BIT];
    end else if (powerup_ff) begin
      low_supply_ff <= 1'b0;
    end else if (low_seen) begin
      low_supply_ff <= 1'b1;
    end else if (wr_ctrl2 && !host_wdata[LOW_SUPPLY_BIT]) begin
      low_supply_ff <= 1'b0;
    end
  end

  // Running flag: undefined at power-up, so it starts low and waits for software
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      osc_run_ff <= CTRL2_RESET[OSC_RUN_BIT];
    end else if (halt_seen) begin
      osc_run_ff <= 1'b0;
    end else if (wr_ctrl2) begin
      osc_run_ff <= host_wdata[OSC_RUN_BIT];
    end
  end

  // Read data register; unmapped addresses read zero
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      host_rdata <= UNMAPPED_RD;
    end else if (host_rd_en) begin
      case (host_addr)
        ADDR_TRIM:  host_rdata <= trim_ff;
        ADDR_CTRL1: host_rdata <= ctrl1_ff;
        ADDR_CTRL2: host_rdata <= {thresh_sel_ff, low_supply_ff, osc_run_ff, powerup_ff,
                                   ctrl2_low_ff};
        default:    host_rdata <= UNMAPPED_RD;
      endcase
    end
  end

  assign supply_threshold_select = thresh_sel_ff;

  // ----------------------------------------------------------------
  // Crossing of the trim setting into the crystal domain
  // ----------------------------------------------------------------
  logic [7:0] trim_sync;                       // Trim after two crystal stages
  logic [7:0] trim_prev_ff;                    // Previous synchronised sample
  logic [7:0] x_trim_ff;                       // Trim in use by the counter

  bit_sync #(.W(8)) u_trim_sync (
    .clk   (xtal_clk),
    .rst_n (xtal_rst_n),
    .d     (trim_ff),
    .q     (trim_sync)
  );

  // Adopt a new trim only when two samples agree, so skewed bits never mix
  always_ff @(posedge xtal_clk or negedge xtal_rst_n) begin
    if (!xtal_rst_n) begin
      trim_prev_ff <= TRIM_RESET;
      x_trim_ff    <= TRIM_RESET;
    end else begin
      trim_prev_ff <= trim_sync;
      if (trim_prev_ff == trim_sync) begin
        x_trim_ff <= trim_sync;
      end
    end
  end

  // ----------------------------------------------------------------
  // Second counter with periodic correction (crystal domain)
  // ----------------------------------------------------------------
  localparam logic [5:0] SHORT_LAST = 6'(SHORT_PERIOD_S - 1);
  localparam logic [5:0] LONG_LAST  = 6'(LONG_PERIOD_S - 1);

  logic signed [17:0] sec_cnt_ff;              // Crystal cycles within the second
  logic        [5:0]  period_cnt_ff;           // Second within the correction period
  logic               x_tick_tgl_ff;           // Toggles once per second
  logic               x_alive_tgl_ff;          // Toggles every crystal cycle
  logic signed [17:0] sec_last;                // Final count of the current second
  logic        [5:0]  period_last;             // Final second of the period
  logic               corr_sec;                // This second carries the correction

  // The correction second is the first of each period; the rest stay nominal
  assign corr_sec    = (period_cnt_ff == 6'd0);
  assign period_last = x_trim_ff[TRIM_STEP_SEL_BIT] ? LONG_LAST
                                                    : SHORT_LAST;
  // A fast crystal needs a longer second, a slow one a shorter second
  assign sec_last    = 18'(COUNTS_PER_SEC - 1)
                     + (corr_sec ? 18'(trim_delta(x_trim_ff)) : 18'sd0);

  // Only the internal count is trimmed; the crystal clock itself is never gated
  always_ff @(posedge xtal_clk or negedge xtal_rst_n) begin
    if (!xtal_rst_n) begin
      sec_cnt_ff    <= '0;
      period_cnt_ff <= '0;
      x_tick_tgl_ff <= 1'b0;
    end else if (sec_cnt_ff >= sec_last) begin
      sec_cnt_ff    <= '0;
      x_tick_tgl_ff <= ~x_tick_tgl_ff;
      period_cnt_ff <= (period_cnt_ff >= period_last) ? 6'd0 : period_cnt_ff + 6'd1;
    end else begin
      sec_cnt_ff    <= sec_cnt_ff + 18'sd1;
    end
  end

  // Heartbeat used by the halt detector in the core domain
  always_ff @(posedge xtal_clk or negedge xtal_rst_n) begin
    if (!xtal_rst_n) begin
      x_alive_tgl_ff <= 1'b0;
    end else begin
      x_alive_tgl_ff <= ~x_alive_tgl_ff;
    end
  end

  // Every second after the first of the period must be the plain second length
  a_nominal_second: assert property (@(posedge xtal_clk) disable iff (!xtal_rst_n)
    (period_cnt_ff != 6'd0) |-> (sec_last == 18'(COUNTS_PER_SEC - 1)))
    else $error("nominal second carries a correction");

  // Codes with no net correction leave the correction second nominal
  a_zero_codes: assert property (@(posedge xtal_clk) disable iff (!xtal_rst_n)
    (x_trim_ff[6:0] inside {7'h00, 7'h01, 7'h40, 7'h41}) |-> (sec_last == 18'(COUNTS_PER_SEC - 1)))
    else $error("zero-correction code changed the second");

  // ----------------------------------------------------------------
  // Crossing of crystal events into the core domain
  // ----------------------------------------------------------------
  logic [1:0] evt_sync;                        // Synchronised second and heartbeat toggles
  logic [1:0] evt_prev_ff;                     // Previous synchronised toggles
  logic       sec_evt;                         // A timekept second ended
  logic       alive_evt;                       // Crystal is running

  bit_sync #(.W(2)) u_evt_sync (
    .clk   (core_clk),
    .rst_n (core_rst_n),
    .d     ({x_tick_tgl_ff, x_alive_tgl_ff}),
    .q     (evt_sync)
  );

  // Edge detection works on the second stage and its delayed copy only
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      evt_prev_ff <= 2'b00;
      second_tick <= 1'b0;
    end else begin
      evt_prev_ff <= evt_sync;
      second_tick <= sec_evt;
    end
  end

  assign sec_evt   = evt_sync[1] ^ evt_prev_ff[1];
  assign alive_evt = evt_sync[0] ^ evt_prev_ff[0];

  // ----------------------------------------------------------------
  // Oscillation halt detector
  // ----------------------------------------------------------------
  logic [31:0] silence_cnt_ff;                 // Core cycles since the last heartbeat

  // A crystal that stalls freezes its heartbeat; the core clock keeps counting
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      silence_cnt_ff <= '0;
    end else if (alive_evt) begin
      silence_cnt_ff <= '0;
    end else if (silence_cnt_ff < 32'(HALT_LEN)) begin
      silence_cnt_ff <= silence_cnt_ff + 32'd1;
    end
  end

  assign halt_seen = (silence_cnt_ff == 32'(HALT_LEN - 1)) && !alive_evt;

  a_halt_clears_run: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    halt_seen |=> !osc_run_ff)
    else $error("halt did not clear the running flag");

  a_run_stays_low: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    (!osc_run_ff && !(wr_ctrl2 && host_wdata[OSC_RUN_BIT])) |=> !osc_run_ff)
    else $error("running flag rose without a write of one");

  // ----------------------------------------------------------------
  // Supply sampling window, once per second
  // ----------------------------------------------------------------
  logic [31:0] sample_cnt_ff;                  // Remaining cycles of the window
  logic        below_sync;                     // Comparator after two stages

  bit_sync #(.W(1)) u_below_sync (
    .clk   (core_clk),
    .rst_n (core_rst_n),
    .d     (supply_below),
    .q     (below_sync)
  );

  // Open a window each second unless a drop is already recorded
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      sample_cnt_ff     <= '0;
      supply_monitor_en <= 1'b0;
    end else if (low_supply_ff || low_seen) begin
      sample_cnt_ff     <= '0;
      supply_monitor_en <= 1'b0;
    end else if (sec_evt) begin
      sample_cnt_ff     <= 32'(SAMPLE_LEN);
      supply_monitor_en <= 1'b1;
    end else if (sample_cnt_ff > 32'd1) begin
      sample_cnt_ff     <= sample_cnt_ff - 32'd1;
    end else begin
      sample_cnt_ff     <= '0;
      supply_monitor_en <= 1'b0;
    end
  end

  // Comparator result counts only inside an open window
  assign low_seen = supply_monitor_en && below_sync && !powerup_ff;

  a_sampling_stops: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    low_supply_ff |=> !supply_monitor_en)
    else $error("sampling continued with low-supply flag set");

  a_low_sticky: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    (low_supply_ff && !powerup_ff && !(wr_ctrl2 && !host_wdata[LOW_SUPPLY_BIT])) |=> low_supply_ff)
    else $error("low-supply flag cleared without a zero write");

  a_powerup_one_write: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    (!powerup_ff && wr_ctrl2 && host_wdata[POWERUP_BIT]) |=> !powerup_ff)
    else $error("writing one set the power-up flag");

  a_powerup_forces: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    powerup_ff ##1 powerup_ff |-> (trim_ff == 8'h00 && ctrl1_ff == 8'h00 && !thresh_sel_ff))
    else $error("bits not held clear under the power-up flag");

  a_reset_values: assert property (@(posedge core_clk)
    $rose(core_rst_n) |-> (powerup_ff && !low_supply_ff && trim_ff == 8'h00))
    else $error("wrong flag values after power-up");

  a_window_length: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    $rose(supply_monitor_en) |-> (sample_cnt_ff == 32'(SAMPLE_LEN)))
    else $error("sampling window started with wrong length");

endmodule : rtc_trim_and_health_flags

`default_nettype wire

// ===== hdl/rtc_trim_pkg.sv
// Constants, register map and trim decoding for the clock rate trim and health flags
package rtc_trim_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_TRIM  = 4'h7;   // Clock rate trim register
  localparam logic [3:0] ADDR_CTRL1 = 4'hE;   // First control register
  localparam logic [3:0] ADDR_CTRL2 = 4'hF;   // Status and monitor control

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TRIM_STEP_SEL_BIT   = 7;     // Step-size select
  localparam int TRIM_VALUE_MSB_BIT  = 6;     // Top trim value bit (sign side)
  localparam int TRIM_VALUE_LSB_BIT  = 0;     // Bottom trim value bit
  localparam int THRESH_SEL_BIT      = 7;     // Supply threshold select
  localparam int LOW_SUPPLY_BIT      = 6;     // Low-supply flag
  localparam int OSC_RUN_BIT         = 5;     // Oscillation-running flag, low = halt seen
  localparam int POWERUP_BIT         = 4;     // Power-up flag

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TRIM_RESET  = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h10; // Power-up flag high, rest low
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // ----------------------------------------------------------------
  // Timekeeping and timing constants
  // ----------------------------------------------------------------
  localparam int  CORE_CLK_KHZ     = 20000;   // Core clock rate
  localparam int  XTAL_COUNTS_SEC  = 32768;   // Crystal cycles per nominal second
  localparam int  SHORT_PERIOD_S   = 20;      // Correction period, coarse steps
  localparam int  LONG_PERIOD_S    = 60;      // Correction period, fine steps
  localparam int  SAMPLE_TIME_US   = 7800;    // Supply sampling interval
  localparam int  SAMPLE_CYCLES    = SAMPLE_TIME_US * CORE_CLK_KHZ / 1000;  // Longest: rounded down
  localparam int  HALT_TIME_US     = 120;     // Crystal silence taken as a halt
  localparam int  HALT_CYCLES      = (HALT_TIME_US * CORE_CLK_KHZ + 999) / 1000;  // Least: rounded up

  // ----------------------------------------------------------------
  // Trim code to crystal counts added to the correction second
  // ----------------------------------------------------------------
  function automatic logic signed [8:0] trim_delta(input logic [7:0] code);
    logic [8:0] v;
    logic [8:0] m;
    v = {2'b00, code[6:0]};
    m = 9'h080 - v;
    trim_delta = '0;
    if (!code[6]) begin
      if (v > 9'h001) begin
        trim_delta = signed'((v - 9'h001) << 1);
      end
    end else if (v > 9'h041) begin
      trim_delta = -signed'(m << 1);
    end
  endfunction : trim_delta

endpackage : rtc_trim_pkg
